// File: shared/sfr_pkg.sv
package sfr_pkg;

   // Special register addresses
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] SFR_PTR_LO = 8'h82;
   localparam logic [7:0] SFR_PTR_HI = 8'h83;
   localparam logic [7:0] SFR_RSVD = 8'h84;
   localparam logic [7:0] SFR_PWR_CTL = 8'h87;
   localparam logic [7:0] SFR_SYS_CTL = 8'hbf;
   localparam logic [7:0] SFR_STATUS = 8'hd0;
   localparam logic [7:0] SFR_WORK = 8'he0;

   // Every implemented special register address; the rest read 00h and drop writes
   localparam int MAPPED_COUNT = 28;
   localparam logic [7:0] MAPPED_ADDR [MAPPED_COUNT] = '{
      8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
      8'h90, 8'h98, 8'h99, 8'h9f, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hbf,
      8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0
   };

   // Internal RAM regions
   localparam logic [7:0] RAM_BASE = 8'h00;
   localparam logic [7:0] RAM_BANK_END = 8'h1f;
   localparam logic [7:0] RAM_BIT_BASE = 8'h20;
   localparam logic [7:0] RAM_BIT_END = 8'h2f;
   localparam logic [7:0] RAM_BYTE_BASE = 8'h30;
   localparam logic [7:0] RAM_TOP = 8'h7f;
   localparam int RAM_DEPTH = 128;
   localparam int RAM_AW = 7;
   localparam logic [2:0] BANK_PAD = 3'b000;
   localparam logic [2:0] BIT_LSB_ZERO = 3'b000;

   // Program status fields
   localparam int ST_CARRY = 7;
   localparam int ST_HALF = 6;
   localparam int ST_USER = 5;
   localparam int ST_BANK_HI = 4;
   localparam int ST_BANK_LO = 3;
   localparam int ST_RANGE = 2;
   localparam int ST_PARITY = 0;
   localparam logic [7:0] ST_WMASK = 8'hfc;
   localparam logic [7:0] ST_RESET = 8'h00;

   // Power control fields
   localparam int PCTL_BAUD = 7;
   localparam int PCTL_FLAG1 = 3;
   localparam int PCTL_FLAG0 = 2;
   localparam int PCTL_SLEEP = 1;
   localparam int PCTL_IDLE = 0;
   localparam logic [7:0] PCTL_WMASK = 8'h8f;
   localparam logic [7:0] PCTL_RESET = 8'h00;

   // System control fields
   localparam int SYS_WDR = 7;
   localparam int SYS_ALE_OFF = 0;
   localparam logic [7:0] SYS_WMASK = 8'h81;
   localparam logic [7:0] SYS_RESET = 8'h00;
   localparam logic [7:0] SYS_WDR_SET = 8'h80;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BIT_ONE = 8'h01;
   localparam logic [4:0] NIB_MAX = 5'h0f;

   // Bit operation codes
   localparam logic [1:0] BIT_NONE = 2'h0;
   localparam logic [1:0] BIT_SET = 2'h1;
   localparam logic [1:0] BIT_CLR = 2'h2;
   localparam logic [1:0] BIT_TEST = 2'h3;

   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_IDLE = 3'b010,
      PWR_DOWN = 3'b100
   } pwr_state_e;

endpackage : sfr_pkg

// File: design/internal_ram.sv
`timescale 1ns/1ps
module internal_ram
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [RAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   // Contents carry no reset and survive idle and power-down
   logic [7:0] mem [0:RAM_DEPTH-1];

   assign rdata = mem[addr];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
   end

endmodule : internal_ram

// File: design/sfr_system_control.sv
`timescale 1ns/1ps
module sfr_system_control
   import sfr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] mem_addr,
   input wire logic mem_direct,
   input wire logic mem_rn,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] bit_addr,
   input wire logic [1:0] bit_op,
   input wire logic alu_upd,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_cin,
   input wire logic instr_done,
   input wire logic irq_wake,
   input wire logic wdt_overflow,
   input wire logic ale_clk,
   output logic [7:0] rdata_q,
   output logic bit_rdata_q,
   output logic rd_valid_q,
   output logic [15:0] data_pointer_q,
   output logic [7:0] program_status_q,
   output logic [7:0] main_working_q,
   output logic [7:0] power_control_q,
   output logic [7:0] system_control_q,
   output logic baud_doubler_q,
   output logic ale_out_q,
   output logic cpu_halt_q,
   output logic osc_stop_q
);

   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
      return {BANK_PAD, bank, idx};
   endfunction : bank_addr

   function automatic logic [7:0] bit_byte_addr(input logic [7:0] ba);
      // Low half maps onto RAM 20h-2Fh, high half onto registers at x0h/x8h
      return ba[7] ? {ba[7:3], BIT_LSB_ZERO} : {RAM_BIT_BASE[7:4], ba[6:3]};
   endfunction : bit_byte_addr

   function automatic logic sfr_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < MAPPED_COUNT; i++) begin
         if (MAPPED_ADDR[i] == a) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : sfr_mapped

   function automatic logic odd_parity(input logic [7:0] v);
      return ^v;
   endfunction : odd_parity

   function automatic logic nibble_carry(input logic [7:0] a, input logic [7:0] b, input logic c);
      logic [4:0] s;
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
      return s[4];
   endfunction : nibble_carry

   pwr_state_e power_state_q;
   pwr_state_e power_state_d;
   logic [7:0] sfr_mem [0:RAM_DEPTH-1];
   logic [7:0] program_status_d;
   logic [7:0] power_control_d;
   logic [7:0] system_control_d;
   logic [7:0] main_working_d;

   // Access decode
   wire run = (power_state_q == PWR_RUN);
   wire soft_rst = !rst_n || wdt_overflow;
   wire byte_req = mem_rd || mem_wr;
   wire bit_req = (bit_op != BIT_NONE) && !byte_req;
   wire [1:0] bank_sel = {program_status_q[ST_BANK_HI], program_status_q[ST_BANK_LO]};
   wire [7:0] rn_addr = bank_addr(bank_sel, mem_addr[2:0]);
   wire [7:0] byte_addr = mem_rn ? rn_addr : mem_addr;
   wire [7:0] eff_addr = bit_req ? bit_byte_addr(bit_addr) : byte_addr;
   wire eff_direct = bit_req || (mem_direct && !mem_rn);
   wire ram_hit = !eff_addr[7];
   wire sfr_hit = eff_addr[7] && eff_direct && sfr_mapped(eff_addr);

   wire [7:0] ram_rdata;
   wire [7:0] sfr_rdata = (eff_addr == SFR_PTR_LO) ? data_pointer_q[7:0] :
                          (eff_addr == SFR_PTR_HI) ? data_pointer_q[15:8] :
                          (eff_addr == SFR_PWR_CTL) ? power_control_q :
                          (eff_addr == SFR_SYS_CTL) ? system_control_q :
                          (eff_addr == SFR_STATUS) ? program_status_q :
                          (eff_addr == SFR_WORK) ? main_working_q :
                          sfr_mem[eff_addr[RAM_AW-1:0]];
   wire [7:0] cur_byte = ram_hit ? ram_rdata : (sfr_hit ? sfr_rdata : BYTE_ZERO);
   wire [2:0] bit_sel = bit_addr[2:0];
   wire [7:0] bit_mask = BIT_ONE << bit_sel;
   wire cur_bit = cur_byte[bit_sel];
   wire [7:0] bit_new = (bit_op == BIT_SET) ? (cur_byte | bit_mask) : (cur_byte & ~bit_mask);
   wire bit_wr = bit_req && (bit_op == BIT_SET || bit_op == BIT_CLR);
   wire [7:0] wr_byte = bit_req ? bit_new : mem_wdata;
   wire wr_go = run && (mem_wr || bit_wr);
   wire ram_we = wr_go && ram_hit;
   wire sfr_we = wr_go && sfr_hit;
   wire we_ptr_lo = sfr_we && (eff_addr == SFR_PTR_LO);
   wire we_ptr_hi = sfr_we && (eff_addr == SFR_PTR_HI);
   wire we_pwr = sfr_we && (eff_addr == SFR_PWR_CTL);
   wire we_sys = sfr_we && (eff_addr == SFR_SYS_CTL);
   wire we_status = sfr_we && (eff_addr == SFR_STATUS);
   wire we_work = sfr_we && (eff_addr == SFR_WORK);
   wire we_gen = sfr_we && !(we_ptr_lo || we_ptr_hi || we_pwr || we_sys || we_status || we_work);
   wire rd_go = run && (mem_rd || (bit_req && bit_op == BIT_TEST));

   // Arithmetic flag capture
   wire alu_go = run && alu_upd;
   wire [8:0] alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
   wire alu_half = nibble_carry(alu_a, alu_b, alu_cin);
   wire alu_ovf = (alu_a[7] == alu_b[7]) && (alu_sum[7] != alu_a[7]);

   // Power mode control
   wire wake_go = (power_state_q == PWR_IDLE) && irq_wake;
   wire pd_go = run && instr_done && power_control_q[PCTL_SLEEP];
   wire idle_go = run && instr_done && power_control_q[PCTL_IDLE] && !power_control_q[PCTL_SLEEP];

   internal_ram u_ram (
      .clk(clk),
      .wr_en(ram_we),
      .addr(eff_addr[RAM_AW-1:0]),
      .wdata(wr_byte),
      .rdata(ram_rdata)
   );

   always_comb begin
      program_status_d = program_status_q;
      if (we_status) begin
         program_status_d = (wr_byte & ST_WMASK) | (program_status_q & ~ST_WMASK);
      end
      if (alu_go) begin
         program_status_d[ST_CARRY] = alu_sum[8];
         program_status_d[ST_HALF] = alu_half;
         program_status_d[ST_RANGE] = alu_ovf;
      end
      program_status_d[ST_PARITY] = odd_parity(main_working_q);
   end

   assign main_working_d = alu_go ? alu_sum[7:0] : (we_work ? wr_byte : main_working_q);

   always_comb begin
      power_control_d = power_control_q;
      if (we_pwr) begin
         power_control_d = (wr_byte & PCTL_WMASK) | (power_control_q & ~PCTL_WMASK);
      end
      if (wake_go) begin
         power_control_d[PCTL_IDLE] = 1'b0;
      end
   end

   always_comb begin
      system_control_d = system_control_q;
      if (we_sys) begin
         system_control_d = wr_byte & SYS_WMASK;
      end
   end

   always_comb begin
      power_state_d = power_state_q;
      case (power_state_q)
         PWR_RUN: begin
            if (pd_go) begin
               power_state_d = PWR_DOWN;
            end else if (idle_go) begin
               power_state_d = PWR_IDLE;
            end
         end
         PWR_IDLE: begin
            if (irq_wake) begin
               power_state_d = PWR_RUN;
            end
         end
         PWR_DOWN: begin
            power_state_d = PWR_DOWN;
         end
         default: begin
            power_state_d = PWR_RUN;
         end
      endcase
   end

   // Watchdog overflow resets the block but leaves its flag set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         system_control_q <= SYS_RESET;
      end else if (wdt_overflow) begin
         system_control_q <= SYS_WDR_SET;
      end else begin
         system_control_q <= system_control_d;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         power_state_q <= PWR_RUN;
         power_control_q <= PCTL_RESET;
         program_status_q <= ST_RESET;
         main_working_q <= BYTE_ZERO;
         data_pointer_q <= {BYTE_ZERO, BYTE_ZERO};
      end else begin
         power_state_q <= power_state_d;
         power_control_q <= power_control_d;
         program_status_q <= program_status_d;
         main_working_q <= main_working_d;
         if (we_ptr_lo) begin
            data_pointer_q[7:0] <= wr_byte;
         end
         if (we_ptr_hi) begin
            data_pointer_q[15:8] <= wr_byte;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         for (int i = 0; i < RAM_DEPTH; i++) begin
            sfr_mem[i] <= BYTE_ZERO;
         end
      end else if (we_gen) begin
         sfr_mem[eff_addr[RAM_AW-1:0]] <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         rdata_q <= BYTE_ZERO;
         bit_rdata_q <= 1'b0;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_go;
         if (rd_go) begin
            rdata_q <= cur_byte;
            bit_rdata_q <= cur_bit;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         baud_doubler_q <= 1'b0;
         ale_out_q <= 1'b0;
         cpu_halt_q <= 1'b0;
         osc_stop_q <= 1'b0;
      end else begin
         baud_doubler_q <= power_control_d[PCTL_BAUD];
         ale_out_q <= ale_clk && !system_control_d[SYS_ALE_OFF] && (power_state_d != PWR_DOWN);
         cpu_halt_q <= (power_state_d != PWR_RUN);
         osc_stop_q <= (power_state_d == PWR_DOWN);
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   wire ref_half = ({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin}) > NIB_MAX;

   sequence s_idle_wake;
      (power_state_q == PWR_IDLE) && irq_wake && !wdt_overflow;
   endsequence

   sequence s_pd_req;
      run && instr_done && power_control_q[PCTL_SLEEP] && !wdt_overflow;
   endsequence

   a_indirect_blocked: assert property (
      (run && mem_wr && !mem_direct && !mem_rn && mem_addr[7] && !alu_upd && !wdt_overflow)
      |=> $stable(main_working_q) && $stable(data_pointer_q) && $stable(power_control_q))
      else $error("indirect write reached special register space");

   a_pointer_low_write: assert property (
      (run && mem_wr && mem_direct && !mem_rn && mem_addr == SFR_PTR_LO && !wdt_overflow)
      |=> data_pointer_q[7:0] == $past(mem_wdata))
      else $error("data pointer low byte not written");

   a_half_carry_flag: assert property (
      (run && alu_upd && !wdt_overflow) |=> program_status_q[ST_HALF] == $past(ref_half))
      else $error("half carry flag wrong");

   a_parity_tracks: assert property (
      ($past(rst_n) && !$past(wdt_overflow)) |-> program_status_q[ST_PARITY] == odd_parity($past(main_working_q)))
      else $error("parity flag does not follow accumulator");

   a_bank_window: assert property (
      (mem_rn && byte_req) |-> (eff_addr <= RAM_BANK_END) && (eff_addr[4:3] == bank_sel))
      else $error("working register outside selected bank");

   a_bit_ram_window: assert property (
      (bit_req && !bit_addr[7]) |-> (eff_addr >= RAM_BIT_BASE) && (eff_addr <= RAM_BIT_END))
      else $error("bit operation outside bit addressable RAM");

   a_watchdog_flag: assert property (
      wdt_overflow |=> system_control_q[SYS_WDR] && !cpu_halt_q)
      else $error("watchdog reset flag not set");

   a_strobe_quiet: assert property (
      system_control_q[SYS_ALE_OFF] && !we_sys |=> !ale_out_q)
      else $error("latch strobe not inhibited");

   a_idle_wake: assert property (
      s_idle_wake |=> (power_state_q == PWR_RUN) && !power_control_q[PCTL_IDLE] && !cpu_halt_q)
      else $error("idle wake-up failed");

   a_idle_hold: assert property (
      ((power_state_q == PWR_IDLE) && !irq_wake && !wdt_overflow) |=> cpu_halt_q && !osc_stop_q)
      else $error("idle mode not held");

   a_pd_entry: assert property (
      s_pd_req |=> osc_stop_q && cpu_halt_q && !ale_out_q)
      else $error("power-down not entered");

   a_baud_follows: assert property (
      baud_doubler_q == power_control_q[PCTL_BAUD])
      else $error("baud doubler output differs from register");

endmodule : sfr_system_control

// File: verif/test_mcu_sfr_system_control.sv
`timescale 1ns/1ps
module test_mcu_sfr_system_control;
   import sfr_pkg::*;
   logic clk, rst_n, mem_direct, mem_rn, mem_rd, mem_wr, alu_upd, alu_cin;
   logic instr_done, irq_wake, wdt_overflow, ale_clk;
   logic [7:0] mem_addr, mem_wdata, bit_addr, alu_a, alu_b;
   logic [1:0] bit_op;
   logic [7:0] rdata_q, program_status_q, main_working_q, power_control_q, system_control_q;
   logic [15:0] data_pointer_q;
   logic bit_rdata_q, rd_valid_q, baud_doubler_q, ale_out_q, cpu_halt_q, osc_stop_q;
   int fails = 0;
   int checks = 0;

   sfr_system_control dut (
      .clk, .rst_n, .mem_addr, .mem_direct, .mem_rn, .mem_rd, .mem_wr, .mem_wdata,
      .bit_addr, .bit_op, .alu_upd, .alu_a, .alu_b, .alu_cin, .instr_done, .irq_wake,
      .wdt_overflow, .ale_clk, .rdata_q, .bit_rdata_q, .rd_valid_q, .data_pointer_q,
      .program_status_q, .main_working_q, .power_control_q, .system_control_q,
      .baud_doubler_q, .ale_out_q, .cpu_halt_q, .osc_stop_q
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic xfer(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic dir, input logic rn);
      step();
      mem_rd = rd;
      mem_wr = wr;
      mem_addr = a;
      mem_wdata = d;
      mem_direct = dir;
      mem_rn = rn;
      step();
      mem_rd = 1'b0;
      mem_wr = 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b0, 1'b1, a, d, 1'b1, 1'b0);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic dir, input logic [7:0] exp);
      xfer(1'b1, 1'b0, a, 8'h00, dir, 1'b0);
      chk(what, {rd_valid_q, rdata_q}, {1'b1, exp});
   endtask : rdchk

   task automatic bop(input logic [1:0] op, input logic [7:0] ba);
      step();
      bit_op = op;
      bit_addr = ba;
      step();
      bit_op = BIT_NONE;
   endtask : bop

   task automatic alu(input logic [7:0] a, input logic [7:0] b, input logic cin);
      step();
      alu_upd = 1'b1;
      alu_a = a;
      alu_b = b;
      alu_cin = cin;
      step();
      alu_upd = 1'b0;
   endtask : alu

   task automatic done_pulse();
      step();
      instr_done = 1'b1;
      step();
      instr_done = 1'b0;
   endtask : done_pulse

   task automatic wake_pulse();
      step();
      irq_wake = 1'b1;
      step();
      irq_wake = 1'b0;
   endtask : wake_pulse

   task automatic t_pointer();
      wr(SFR_PTR_LO, 8'h5a);
      wr(SFR_PTR_HI, 8'ha5);
      chk("pointer", data_pointer_q, 16'ha55a);
      rdchk("pointer high", SFR_PTR_HI, 1'b1, 8'ha5);
      $display("t_pointer done");
   endtask : t_pointer

   task automatic t_indirect();
      xfer(1'b0, 1'b1, SFR_PTR_LO, 8'h11, 1'b0, 1'b0);
      chk("pointer", data_pointer_q, 16'ha55a);
      rdchk("ind 82h", SFR_PTR_LO, 1'b0, 8'h00);
      rdchk("rsvd", SFR_RSVD, 1'b1, 8'h00);
      wr(8'h81, 8'h3e);
      rdchk("stack", 8'h81, 1'b1, 8'h3e);
      xfer(1'b0, 1'b1, 8'h7f, 8'h3c, 1'b0, 1'b0);
      rdchk("ram 7fh", 8'h7f, 1'b1, 8'h3c);
      wr(8'h00, 8'hc3);
      rdchk("ram 00h", 8'h00, 1'b0, 8'hc3);
      $display("t_indirect done");
   endtask : t_indirect

   task automatic t_banks();
      for (int b = 0; b < 4; b++) begin
         wr(SFR_STATUS, {3'b000, b[1:0], 3'b000});
         xfer(1'b0, 1'b1, 8'h05, 8'(8'h60 + b), 1'b0, 1'b1);
         rdchk("bank reg", 8'(8 * b + 5), 1'b1, 8'(8'h60 + b));
      end
      wr(SFR_STATUS, 8'hff);
      chk("status", program_status_q[7:1], 16'h7e);
      wr(SFR_STATUS, 8'h00);
      $display("t_banks done");
   endtask : t_banks

   task automatic t_alu();
      alu(8'h08, 8'h08, 1'b0);
      chk("sum", main_working_q, 16'h10);
      chk("flags", {program_status_q[7:6], program_status_q[2]}, 16'h2);
      step();
      chk("parity", program_status_q[0], 16'h1);
      alu(8'h80, 8'h80, 1'b0);
      chk("flags", {program_status_q[7:6], program_status_q[2]}, 16'h5);
      step();
      chk("parity", program_status_q[0], 16'h0);
      alu(8'h0f, 8'h00, 1'b1);
      chk("flags cin", {program_status_q[7:6], program_status_q[2]}, 16'h2);
      $display("t_alu done");
   endtask : t_alu

   task automatic t_bits();
      wr(8'h20, 8'h00);
      wr(8'h2f, 8'h00);
      wr(8'h30, 8'h00);
      bop(BIT_SET, 8'h03);
      bop(BIT_SET, 8'h7f);
      rdchk("ram 20h", 8'h20, 1'b1, 8'h08);
      rdchk("ram 2fh", 8'h2f, 1'b1, 8'h80);
      rdchk("ram 30h", 8'h30, 1'b1, 8'h00);
      bop(BIT_TEST, 8'h03);
      chk("bit test", {rd_valid_q, bit_rdata_q}, 16'h3);
      bop(BIT_CLR, 8'h03);
      rdchk("ram 20h", 8'h20, 1'b1, 8'h00);
      bop(BIT_SET, 8'hd5);
      chk("user flag", program_status_q[5], 16'h1);
      bop(BIT_TEST, 8'hd5);
      chk("user flag test", {rd_valid_q, bit_rdata_q}, 16'h3);
      bop(BIT_CLR, 8'hd5);
      chk("user flag", program_status_q[5], 16'h0);
      $display("t_bits done");
   endtask : t_bits

   task automatic t_ale();
      ale_clk = 1'b1;
      step();
      chk("ale", ale_out_q, 16'h1);
      ale_clk = 1'b0;
      step();
      chk("ale", ale_out_q, 16'h0);
      ale_clk = 1'b1;
      wr(SFR_SYS_CTL, 8'h01);
      step();
      chk("ale", ale_out_q, 16'h0);
      wr(SFR_SYS_CTL, 8'h00);
      step();
      chk("ale", ale_out_q, 16'h1);
      $display("t_ale done");
   endtask : t_ale

   task automatic t_power();
      wr(SFR_PWR_CTL, 8'hfc);
      chk("power ctl", power_control_q, 16'h8c);
      chk("baud", baud_doubler_q, 16'h1);
      wr(SFR_PWR_CTL, 8'h01);
      done_pulse();
      chk("halt osc", {cpu_halt_q, osc_stop_q}, 16'h2);
      wr(SFR_PTR_LO, 8'h77);
      chk("pointer", data_pointer_q, 16'ha55a);
      wake_pulse();
      chk("halt osc", {cpu_halt_q, osc_stop_q}, 16'h0);
      chk("power ctl", power_control_q, 16'h00);
      wr(SFR_PWR_CTL, 8'h02);
      done_pulse();
      chk("halt osc", {cpu_halt_q, osc_stop_q}, 16'h3);
      chk("ale", ale_out_q, 16'h0);
      wake_pulse();
      chk("halt osc", {cpu_halt_q, osc_stop_q}, 16'h3);
      chk("pointer", data_pointer_q, 16'ha55a);
      step();
      wdt_overflow = 1'b1;
      step();
      wdt_overflow = 1'b0;
      chk("sysctl", system_control_q, 16'h80);
      chk("halt osc", {cpu_halt_q, osc_stop_q}, 16'h0);
      chk("pointer", data_pointer_q, 16'h0000);
      wr(SFR_SYS_CTL, 8'h00);
      chk("sysctl", system_control_q, 16'h00);
      $display("t_power done");
   endtask : t_power

   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      #20000;
      fails++;
      complete_run();
   end

   initial begin
      {rst_n, mem_direct, mem_rn, mem_rd, mem_wr, alu_upd, alu_cin} = '0;
      {instr_done, irq_wake, wdt_overflow, ale_clk, bit_op} = '0;
      {mem_addr, mem_wdata, bit_addr, alu_a, alu_b} = '0;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_pointer();
      t_indirect();
      t_banks();
      t_alu();
      t_bits();
      t_ale();
      t_power();
      complete_run();
   end
endmodule : test_mcu_sfr_system_control
